// *** rtl/dsa_sequencer.sv ***
// Purpose: dual sar converter sequencing logic, both channels in lock step
// Assumes: bit clock and convert are synchronous to mclk_i, one mclk per level
// Notes: a convert edge during a conversion restarts it
// Operation
// - convert rising edge ends autozero and puts both channels into hold together
// - a 19-stage shift register tests bits from msb to lsb
// - a bit stays on if the converter value does not exceed the input
// - one shift register drives both channels' 18 decision latches
// - a bit is tentatively switched on when its stage starts
// - bit clock rising edge strobes the comparator and stores the decision
// - stored decision reaches the bit switch as its stage pulse ends
// - two serial streams, each bit one bit clock after its decision
// - the sequence advances only on the external bit clock
// - words are 18-bit two's complement, 1FFFF positive full scale
// - each trim switch follows its main bit's decision at the same time
// - after the 19th bit clock further edges are ignored until convert
// - from the 19th bit clock both channels track until the next convert
`timescale 1ns/100ps
module dsa_sequencer (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// control from the driving filter or controller
	input wire logic bit_clock_in_i,
	input wire logic convert_i,
	// comparator decisions, high keeps the tested bit
	input wire logic cmp_left_i,
	input wire logic cmp_right_i,
	// shared analog controls
	output logic autozero_switch_o,
	output logic input_sample_switch_o,
	output logic cmp_strobe_o,
	output logic busy_o,
	// left converter switches
	output logic [17:0] cap_switch_left_o,
	output logic [17:0] trim_switch_left_o,
	// right converter switches
	output logic [17:0] cap_switch_right_o,
	output logic [17:0] trim_switch_right_o,
	// results
	output logic serial_left_o,
	output logic serial_right_o,
	output logic [17:0] word_left_o,
	output logic [17:0] word_right_o,
	output logic word_valid_o
);
	dsa_pkg::dsa_state_t state;
	logic [18:0] sequencer_stage;
	logic bclk_prev;
	logic conv_prev;
	logic bclk_rise;
	logic conv_rise;
	logic strobe;
	logic [1:0] cmp;
	logic [17:0] cap_sw [2];
	logic [17:0] trim_sw [2];
	logic [17:0] word [2];
	logic [1:0] serial;
	logic [1:0] word_valid;

	assign cmp = {cmp_right_i, cmp_left_i};
	assign bclk_rise = bit_clock_in_i & ~bclk_prev;
	assign conv_rise = convert_i & ~conv_prev;
	// edges outside a conversion are gated off here
	assign strobe = bclk_rise & (state == dsa_pkg::DSA_ST_CONV);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_prev <= dsa_pkg::DSA_PREV_RST;
			conv_prev <= dsa_pkg::DSA_PREV_RST;
		end else begin
			bclk_prev <= bit_clock_in_i;
			conv_prev <= convert_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= dsa_pkg::DSA_ST_TRACK;
			sequencer_stage <= dsa_pkg::DSA_SEQ_IDLE;
		end else begin
			case (state)
				dsa_pkg::DSA_ST_TRACK: begin
					if (conv_rise) begin
						state <= dsa_pkg::DSA_ST_CONV;
						sequencer_stage <= dsa_pkg::DSA_SEQ_FIRST;
					end
				end
				dsa_pkg::DSA_ST_CONV: begin
					if (conv_rise) begin
						sequencer_stage <= dsa_pkg::DSA_SEQ_FIRST;
					end else if (bclk_rise && sequencer_stage[18]) begin
						state <= dsa_pkg::DSA_ST_TRACK;
						sequencer_stage <= dsa_pkg::DSA_SEQ_IDLE;
					end else if (bclk_rise) begin
						sequencer_stage <= {sequencer_stage[17:0], 1'b0};
					end
				end
				default: begin
					state <= dsa_pkg::DSA_ST_TRACK;
					sequencer_stage <= dsa_pkg::DSA_SEQ_IDLE;
				end
			endcase
		end
	end

	// both channels share state, so hold and tracking are co-phased
	assign autozero_switch_o = (state == dsa_pkg::DSA_ST_TRACK);
	assign input_sample_switch_o = (state == dsa_pkg::DSA_ST_TRACK);
	assign busy_o = (state == dsa_pkg::DSA_ST_CONV);
	// the 19th edge ends the conversion and latches the words, no bit is tested on it
	assign cmp_strobe_o = strobe & ~sequencer_stage[18];

	genvar c;
	generate
		for (c = 0; c < dsa_pkg::DSA_NUM_CH; c++) begin : g_ch
			dsa_channel_rank u_rank (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.start_i(conv_rise),
				.strobe_i(strobe),
				.stage_i(sequencer_stage),
				.cmp_i(cmp[c]),
				.cap_switch_o(cap_sw[c]),
				.trim_switch_o(trim_sw[c]),
				.serial_o(serial[c]),
				.word_o(word[c]),
				.word_valid_o(word_valid[c])
			);
		end
	endgenerate

	assign cap_switch_left_o = cap_sw[0];
	assign cap_switch_right_o = cap_sw[1];
	assign trim_switch_left_o = trim_sw[0];
	assign trim_switch_right_o = trim_sw[1];
	assign serial_left_o = serial[0];
	assign serial_right_o = serial[1];
	assign word_left_o = word[0];
	assign word_right_o = word[1];
	assign word_valid_o = word_valid[0];

	default clocking dsa_cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	start_hold_a: assert property (
		conv_rise |=> busy_o && !autozero_switch_o && !input_sample_switch_o
			&& sequencer_stage == dsa_pkg::DSA_SEQ_FIRST)
		else $error("convert edge did not start hold");

	stage_order_a: assert property (
		strobe && !sequencer_stage[18] && !conv_rise
			|=> sequencer_stage == {$past(sequencer_stage[17:0]), 1'b0})
		else $error("sequencer stage did not advance by one");

	msb_keep_a: assert property (
		strobe && sequencer_stage[0] && !conv_rise
			|=> cap_switch_left_o[17] == $past(cmp_left_i)
			&& cap_switch_right_o[17] == $past(cmp_right_i))
		else $error("msb decision not kept as compared");

	lockstep_test_a: assert property (
		busy_o |-> ((cap_switch_left_o ^ cap_switch_right_o)
			& {sequencer_stage[0], sequencer_stage[1], sequencer_stage[2],
			sequencer_stage[3], sequencer_stage[4], sequencer_stage[5],
			sequencer_stage[6], sequencer_stage[7], sequencer_stage[8],
			sequencer_stage[9], sequencer_stage[10], sequencer_stage[11],
			sequencer_stage[12], sequencer_stage[13], sequencer_stage[14],
			sequencer_stage[15], sequencer_stage[16], sequencer_stage[17]})
			== dsa_pkg::DSA_BITS_CLEAR)
		else $error("channels test different bits");

	tentative_on_a: assert property (
		$rose(sequencer_stage[5]) |-> cap_switch_left_o[12] && cap_switch_right_o[12]
			&& trim_switch_left_o[12])
		else $error("bit not switched on at its stage");

	comp_strobe_a: assert property (
		busy_o && bclk_rise && !sequencer_stage[18] |-> cmp_strobe_o)
		else $error("comparator not strobed on bit clock");

	apply_fall_a: assert property (
		$fell(sequencer_stage[3]) && busy_o && !$past(conv_rise)
			|-> cap_switch_left_o[14] == $past(cmp_left_i)
			&& cap_switch_right_o[14] == $past(cmp_right_i))
		else $error("decision not applied at stage end");

	serial_delay_a: assert property (
		strobe && sequencer_stage[5] && !conv_rise
			|=> serial_left_o == $past(cap_switch_left_o[13])
			&& serial_right_o == $past(cap_switch_right_o[13]))
		else $error("serial bit not one bit clock late");

	serial_msb_a: assert property (
		strobe && sequencer_stage[1] && !conv_rise
			|=> serial_left_o == !$past(cap_switch_left_o[17]))
		else $error("serial stream does not start with sign bit");

	clock_only_a: assert property (
		busy_o && !bclk_rise && !conv_rise |=> $stable(sequencer_stage))
		else $error("sequence moved without a bit clock");

	track_at_end_a: assert property (
		strobe && sequencer_stage[18] && !conv_rise
			|=> input_sample_switch_o && autozero_switch_o && !busy_o && word_valid_o)
		else $error("no return to tracking on 19th clock");

	lockout_a: assert property (
		!busy_o && !conv_rise |=> !busy_o && sequencer_stage == dsa_pkg::DSA_SEQ_IDLE)
		else $error("bit clock accepted after conversion end");

	full_conv_c: cover property (word_valid_o && word_left_o == dsa_pkg::DSA_CODE_POS_FULL);
	neg_word_c: cover property (word_valid_o && word_right_o == dsa_pkg::DSA_CODE_NEG_FULL);
	restart_c: cover property (busy_o && conv_rise);
	idle_clock_c: cover property (!busy_o && bclk_rise);
endmodule

// *** rtl/dsa_pkg.sv ***
// Purpose: shared constants and types of the dual sar sequencer
// Assumes: one clock, all pins synchronous to it
// Notes: stage vector bit 0 is the first stage (msb test)
package dsa_pkg;
	localparam int DSA_NUM_BITS = 18;
	localparam int DSA_NUM_STAGES = 19;
	localparam int DSA_NUM_CH = 2;
	// stage vector values
	localparam logic [18:0] DSA_SEQ_IDLE = 19'h00000;
	localparam logic [18:0] DSA_SEQ_FIRST = 19'h00001;
	localparam logic [17:0] DSA_BITS_CLEAR = 18'h00000;
	// edge detector reset values, high so a pin held high at release is no edge
	localparam logic DSA_PREV_RST = 1'b1;
	// two's complement codes of the output word
	localparam logic [17:0] DSA_CODE_POS_FULL = 18'h1FFFF;
	localparam logic [17:0] DSA_CODE_ZERO = 18'h00000;
	localparam logic [17:0] DSA_CODE_MINUS_ONE = 18'h3FFFF;
	localparam logic [17:0] DSA_CODE_NEG_FULL = 18'h20000;
	typedef enum logic [1:0] {
		DSA_ST_TRACK = 2'b01,
		DSA_ST_CONV = 2'b10
	} dsa_state_t;
endpackage

// *** rtl/dsa_channel_rank.sv ***
// Purpose: one channel's rank of decision latches, switches and serial out
// Assumes: stage vector and strobe come from the shared sequencer
// Notes: switches are combinational from latched state
`timescale 1ns/100ps
module dsa_channel_rank (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// from the sequencer
	input wire logic start_i,
	input wire logic strobe_i,
	input wire logic [18:0] stage_i,
	// comparator decision, high keeps the bit
	input wire logic cmp_i,
	// converter switches
	output logic [17:0] cap_switch_o,
	output logic [17:0] trim_switch_o,
	// results
	output logic serial_o,
	output logic [17:0] word_o,
	output logic word_valid_o
);
	logic [17:0] keep;
	logic [17:0] done;
	logic pend;

	genvar i;
	generate
		for (i = 0; i < dsa_pkg::DSA_NUM_BITS; i++) begin : g_bit
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					keep[17-i] <= 1'b0;
					done[17-i] <= 1'b0;
				end else if (start_i) begin
					keep[17-i] <= 1'b0;
					done[17-i] <= 1'b0;
				end else if (strobe_i && stage_i[i]) begin
					keep[17-i] <= cmp_i;
					done[17-i] <= 1'b1;
				end
			end
			// tentative on during its stage, then the stored decision
			assign cap_switch_o[17-i] = stage_i[i] | (done[17-i] & keep[17-i]);
			// trim bit mirrors the main bit in the same cycle
			assign trim_switch_o[17-i] = cap_switch_o[17-i];
		end
	endgenerate

	// each decision leaves one bit clock later, msb first
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_o <= 1'b0;
			pend <= 1'b0;
		end else if (strobe_i) begin
			serial_o <= pend;
			// msb is the sign: kept msb means non-negative input
			pend <= stage_i[0] ? ~cmp_i : cmp_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			word_o <= dsa_pkg::DSA_BITS_CLEAR;
			word_valid_o <= 1'b0;
		end else begin
			word_valid_o <= strobe_i & stage_i[18];
			if (strobe_i && stage_i[18]) begin
				word_o <= {~keep[17], keep[16:0]};
			end
		end
	end
endmodule

// *** bench/dsa_ctl_model.sv ***
// Purpose: controller model driving convert, bit clock and comparators
// Assumes: levels change 1 ns after a rising mclk edge
// Notes: comparator judged from switches against a held target code
`timescale 1ns/100ps
module dsa_ctl_model (
	// clock
	input wire logic mclk_i,
	// converter switches seen by the comparators
	input wire logic [17:0] cap_left_i,
	input wire logic [17:0] cap_right_i,
	// controls and decisions
	output logic convert_o,
	output logic bit_clock_o,
	output logic cmp_left_o,
	output logic cmp_right_o
);
	logic [17:0] tgt_l = 18'h00000;
	logic [17:0] tgt_r = 18'h00000;
	initial begin
		convert_o = 1'b0;
		bit_clock_o = 1'b0;
	end
	// keep while the trial value stays at or below the held input
	assign cmp_left_o = (cap_left_i <= tgt_l);
	assign cmp_right_o = (cap_right_i <= tgt_r);
	task automatic step(input logic c, input logic b);
		@(posedge mclk_i);
		#1;
		convert_o = c;
		bit_clock_o = b;
	endtask
	task automatic convert(input logic [17:0] l, input logic [17:0] r, input int clocks);
		// offset binary keep pattern of a two's complement code
		tgt_l = l ^ 18'h20000;
		tgt_r = r ^ 18'h20000;
		step(1'b1, 1'b0);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int k = 0; k < clocks; k++) begin
			step(1'b0, 1'b1);
			step(1'b0, 1'b1);
			step(1'b0, 1'b0);
			step(1'b0, 1'b0);
		end
		repeat (4) step(1'b0, 1'b0);
	endtask
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench of the dual sar sequencer
// Assumes: controller model drives convert, bit clock and comparators
// Notes: results read back from both serial streams and both words
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	logic mclk_i;
	logic rst_i = 1'b1;
	logic bclk, conv, cmp_l, cmp_r, az, samp, strobe, busy, ser_l, ser_r, valid;
	logic [17:0] cap_l, trim_l, cap_r, trim_r, word_l, word_r, sh_l, sh_r, got_l, got_r;
	int error_cnt = 0;
	int samples_checked = 0;
	int nvalid = 0;
	int nf = 0;
	int cyc = 0;
	int nstrobe = 0;
	// left code, right code: full scales, zero, minus one, alternating
	logic [17:0] rows [4][2] = '{'{18'h1FFFF, 18'h20000}, '{18'h00000, 18'h3FFFF},
		'{18'h2AAAA, 18'h15555}, '{18'h3FFFF, 18'h00000}};
	dsa_sequencer i_dsa_sequencer (.mclk_i(mclk_i), .rst_i(rst_i), .bit_clock_in_i(bclk),
		.convert_i(conv), .cmp_left_i(cmp_l), .cmp_right_i(cmp_r),
		.autozero_switch_o(az), .input_sample_switch_o(samp), .cmp_strobe_o(strobe),
		.busy_o(busy), .cap_switch_left_o(cap_l), .trim_switch_left_o(trim_l),
		.cap_switch_right_o(cap_r), .trim_switch_right_o(trim_r), .serial_left_o(ser_l),
		.serial_right_o(ser_r), .word_left_o(word_l), .word_right_o(word_r),
		.word_valid_o(valid));
	dsa_ctl_model i_dsa_ctl_model (.mclk_i(mclk_i), .cap_left_i(cap_l), .cap_right_i(cap_r),
		.convert_o(conv), .bit_clock_o(bclk), .cmp_left_o(cmp_l), .cmp_right_o(cmp_r));
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// mid-cycle sampling keeps clear of the registered outputs' updates
	always @(negedge mclk_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			wrap_up();
		end
		if (valid === 1'b1) begin
			nvalid++;
			got_l = word_l;
			got_r = word_r;
		end
		if (strobe === 1'b1) begin
			nstrobe++;
		end
		`CHK({trim_l, trim_r}, {cap_l, cap_r})
	end
	always @(negedge bclk) begin
		if (rst_i === 1'b0) begin
			sh_l = {sh_l[16:0], ser_l};
			sh_r = {sh_r[16:0], ser_r};
			`CHK({samp, az, busy}, {nf >= 18, nf >= 18, nf < 18})
			nf++;
		end
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		`CHK({az, samp, busy, strobe, valid, ser_l, ser_r}, 7'h60)
		`CHK({word_l, word_r, cap_l, cap_r}, 72'h0)
		for (int i = 0; i < 4; i++) begin
			nf = 0;
			i_dsa_ctl_model.convert(rows[i][0], rows[i][1], 19);
			`CHK({got_l, got_r}, {rows[i][0], rows[i][1]})
			`CHK({sh_l, sh_r}, {rows[i][0], rows[i][1]})
		end
		// aborted conversion then restart, then a free-running 64-clock sample period
		nf = 0;
		i_dsa_ctl_model.convert(18'h15555, 18'h2AAAA, 5);
		nf = 0;
		i_dsa_ctl_model.convert(18'h00001, 18'h3FFFE, 64);
		`CHK({got_l, got_r}, {18'h00001, 18'h3FFFE})
		`CHK(nvalid, 5)
		// reset in mid-conversion: back to tracking, results cleared
		nf = 0;
		i_dsa_ctl_model.convert(18'h2AAAA, 18'h15555, 3);
		`CHK(busy, 1'b1)
		rst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		`CHK({az, samp, busy, strobe, valid, ser_l, ser_r}, 7'h60)
		`CHK({word_l, word_r, cap_l, cap_r}, 72'h0)
		rst_i = 1'b0;
		// a convert right after release must still be taken
		nf = 0;
		i_dsa_ctl_model.convert(18'h3FFFF, 18'h1FFFF, 19);
		`CHK({got_l, got_r}, {18'h3FFFF, 18'h1FFFF})
		`CHK({sh_l, sh_r}, {18'h3FFFF, 18'h1FFFF})
		`CHK(nvalid, 6)
		// 18 strobes per full conversion, 5 and 3 for the cut ones, none while tracking
		`CHK(nstrobe, 116)
		wrap_up();
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
endmodule
